// file: logic/twm_channel.sv
// Purpose: One compare output channel: action on match, TOP and force
// Assumes: Events are single-cycle pulses on mclk_in
// Notes:   Channel A passes 1 for IS_CHAN_A to allow its toggle cases
module twm_channel
  import twm_pkg::*;
#(
  parameter bit IS_CHAN_A = 1'b1
) (
  input  wire logic       mclk_in,
  input  wire logic       rstn_in,
  input  wire logic [1:0] out_mode_in,
  input  wire logic [3:0] wmode_in,
  input  wire twm_kind_t  kind_in,
  input  wire twm_evt_t   evt_in,
  input  wire logic       cmp_eq_top_in,
  input  wire logic       force_in,
  input  wire logic       dir_out_in,
  output logic            wave_out,
  output logic            connect_out,
  output logic            drive_en_out
);

  logic wave_reg;
  logic wave_next;
  logic conn_reg;
  logic en_reg;
  logic toggle_ok;
  logic conn_next;
  logic match_eff;

  // ----------------------------------------------------------------
  // Action decode
  // ----------------------------------------------------------------
  // Toggle in PWM only on channel A in modes TWM_WM_FAST_A and TWM_WM_PFC_CMPA
  assign toggle_ok = IS_CHAN_A &&
    (((kind_in == TWM_K_FAST) && (wmode_in == TWM_WM_FAST_A)) ||
     (((kind_in == TWM_K_PHASE) || (kind_in == TWM_K_PFC)) &&
      ((wmode_in == TWM_WM_PFC_CMPA) || (wmode_in == TWM_WM_FAST_CAP))));

  assign conn_next = (out_mode_in == 2'b00) ? 1'b0 :
                     (out_mode_in == 2'b01 && kind_in != TWM_K_NONPWM) ? toggle_ok :
                     !(wmode_in == TWM_WM_RSVD);

  // Fast PWM set/clear modes: match at TOP ignored, TOP action still applies
  assign match_eff = evt_in.match &&
    !((kind_in == TWM_K_FAST) && out_mode_in[1] && cmp_eq_top_in);

  always_comb begin
    wave_next = wave_reg;
    unique case (kind_in)
      TWM_K_NONPWM: begin
        // Force acts as a match here only; no flag, no counter clear
        if (match_eff || force_in) begin
          unique case (out_mode_in)
            2'b01:   wave_next = !wave_reg;
            2'b10:   wave_next = 1'b0;
            2'b11:   wave_next = 1'b1;
            default: wave_next = wave_reg;
          endcase
        end
      end
      TWM_K_FAST: begin
        if (out_mode_in == 2'b01) begin
          if (match_eff && toggle_ok) wave_next = !wave_reg;
        end else if (out_mode_in[1]) begin
          if (evt_in.at_top) wave_next = !out_mode_in[0];
          else if (match_eff) wave_next = out_mode_in[0];
        end
      end
      TWM_K_PHASE, TWM_K_PFC: begin
        if (out_mode_in == 2'b01) begin
          if (match_eff && toggle_ok) wave_next = !wave_reg;
        end else if (out_mode_in[1] && match_eff) begin
          wave_next = evt_in.up ? out_mode_in[0] : !out_mode_in[0];
        end
      end
      default: wave_next = wave_reg;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wave_reg <= 1'b0;
      conn_reg <= 1'b0;
      en_reg   <= 1'b0;
    end else begin
      wave_reg <= wave_next;
      conn_reg <= conn_next;
      en_reg   <= conn_next && dir_out_in;
    end
  end

  assign wave_out     = wave_reg;
  assign connect_out  = conn_reg;
  assign drive_en_out = en_reg;

endmodule // twm_channel

// file: logic/twm_pkg.sv
// Purpose: Constants and types for the timer waveform mode control block
// Assumes: Avalon-MM slave, 32-bit words, registers in low 8 bits
// Notes:   Offsets are byte addresses
package twm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  TWM_OFS_CTRL_A    = 4'h0;
  localparam logic [3:0]  TWM_OFS_CTRL_B    = 4'h4;
  localparam logic [3:0]  TWM_OFS_PIN_DIR   = 4'h8;
  localparam logic [3:0]  TWM_OFS_STATUS    = 4'hc;
  localparam logic [7:0]  TWM_CTRL_A_RST    = 8'h00;
  localparam logic [7:0]  TWM_CTRL_B_RST    = 8'h00;
  localparam logic [7:0]  TWM_CTRL_B_WMASK  = 8'hdf;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TWM_A_MODE_A_POS = 6;
  localparam int TWM_A_MODE_B_POS = 4;
  localparam int TWM_A_FORCE_A    = 3;
  localparam int TWM_A_FORCE_B    = 2;
  localparam int TWM_A_WLOW_POS   = 0;
  localparam int TWM_B_WHIGH_POS  = 3;

  // ----------------------------------------------------------------
  // Counter values
  // ----------------------------------------------------------------
  localparam logic [15:0] TWM_MAX      = 16'hffff;
  localparam logic [15:0] TWM_TOP_8B   = 16'h00ff;
  localparam logic [15:0] TWM_TOP_9B   = 16'h01ff;
  localparam logic [15:0] TWM_TOP_10B  = 16'h03ff;
  localparam logic [15:0] TWM_BOTTOM   = 16'h0000;

  // ----------------------------------------------------------------
  // Waveform mode numbers
  // ----------------------------------------------------------------
  localparam logic [3:0] TWM_WM_NORMAL   = 4'h0;
  localparam logic [3:0] TWM_WM_CLR_CMPA = 4'h4;
  localparam logic [3:0] TWM_WM_PFC_CMPA = 4'h9;
  localparam logic [3:0] TWM_WM_CLR_CAP  = 4'hc;
  localparam logic [3:0] TWM_WM_RSVD     = 4'hd;
  localparam logic [3:0] TWM_WM_FAST_CAP = 4'he;
  localparam logic [3:0] TWM_WM_FAST_A   = 4'hf;

  typedef enum logic [1:0] {
    TWM_TOP_FIXED = 2'h0,
    TWM_TOP_CMPA  = 2'h1,
    TWM_TOP_CAP   = 2'h2
  } twm_top_src_t;

  typedef enum logic [1:0] {
    TWM_AT_IMMEDIATE = 2'h0,
    TWM_AT_TOP       = 2'h1,
    TWM_AT_BOTTOM    = 2'h2,
    TWM_AT_MAX       = 2'h3
  } twm_when_t;

  typedef enum logic [3:0] {
    TWM_K_NONPWM = 4'b0001,
    TWM_K_FAST   = 4'b0010,
    TWM_K_PHASE  = 4'b0100,
    TWM_K_PFC    = 4'b1000
  } twm_kind_t;

  // Decoded waveform mode
  typedef struct packed {
    twm_kind_t    kind;
    twm_top_src_t top_src;
    logic [15:0]  top_fixed;
    twm_when_t    update_at;
    twm_when_t    ovf_at;
    logic         reserved;
  } twm_mode_t;

  // Counter events seen by each channel
  typedef struct packed {
    logic match;
    logic at_top;
    logic up;
  } twm_evt_t;

endpackage : twm_pkg

// file: logic/twm_top.sv
// Purpose: Waveform mode decode, control registers and compare outputs
// Assumes: Counter, compare and capture values come from the timer core
// Notes:   Registers sit on Avalon-MM, one cycle of waitrequest per access
module twm_top
  import twm_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Timer core
  input  wire logic [15:0] counter_value_in,
  input  wire logic        count_up_in,
  input  wire logic        count_tick_in,
  input  wire logic [15:0] chan_a_compare_value_in,
  input  wire logic [15:0] chan_b_compare_value_in,
  input  wire logic [15:0] capture_value_in,
  output logic [15:0]      top_value_out,
  output logic [1:0]       update_at_out,
  output logic [1:0]       ovf_at_out,
  output logic             dual_slope_out,
  output logic             overflow_flag_set_out,
  output logic             compare_load_out,
  output logic             count_clear_out,
  output logic [2:0]       clock_select_out,
  // Compare pins
  output logic             chan_a_wave_pin_out,
  output logic             chan_a_wave_pin_oe_out,
  output logic             chan_a_override_out,
  output logic             chan_b_wave_pin_out,
  output logic             chan_b_wave_pin_oe_out,
  output logic             chan_b_override_out
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic twm_mode_t decode_mode(input logic [3:0] m);
    twm_mode_t d;
    d.kind      = TWM_K_NONPWM;
    d.top_src   = TWM_TOP_FIXED;
    d.top_fixed = TWM_MAX;
    d.update_at = TWM_AT_IMMEDIATE;
    d.ovf_at    = TWM_AT_MAX;
    d.reserved  = 1'b0;
    unique case (m)
      4'h0: d.top_fixed = TWM_MAX;
      4'h4: d.top_src = TWM_TOP_CMPA;
      4'hc: d.top_src = TWM_TOP_CAP;
      4'hd: d.reserved = 1'b1;
      4'h1, 4'h2, 4'h3, 4'ha, 4'hb: begin
        d.kind      = TWM_K_PHASE;
        d.update_at = TWM_AT_TOP;
        d.ovf_at    = TWM_AT_BOTTOM;
      end
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: begin
        d.kind      = TWM_K_FAST;
        d.update_at = TWM_AT_TOP;
        d.ovf_at    = TWM_AT_TOP;
      end
      default: begin
        d.kind      = TWM_K_PFC;
        d.update_at = TWM_AT_BOTTOM;
        d.ovf_at    = TWM_AT_BOTTOM;
      end
    endcase
    unique case (m)
      4'h1, 4'h5: d.top_fixed = TWM_TOP_8B;
      4'h2, 4'h6: d.top_fixed = TWM_TOP_9B;
      4'h3, 4'h7: d.top_fixed = TWM_TOP_10B;
      4'h8, 4'ha, 4'he: d.top_src = TWM_TOP_CAP;
      4'h9, 4'hb, 4'hf: d.top_src = TWM_TOP_CMPA;
      default: d.top_fixed = d.top_fixed;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic [1:0]  pin_dir_reg;
  logic        force_a_reg;
  logic        force_b_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [15:0] top_reg;
  logic [1:0]  upd_reg;
  logic [1:0]  ovf_at_reg;
  logic        dual_reg;
  logic        ovf_reg;
  logic        load_reg;
  logic        clr_reg;
  logic        ovf_next;
  logic        load_next;

  wire logic [3:0]  waveform_mode;
  wire twm_mode_t   mode_dec;
  wire logic [15:0] top_value;
  wire logic        at_top;
  wire logic        at_bottom;
  wire logic        at_max;
  wire logic        wr_ctrl_a;
  wire logic        wr_ctrl_b;
  wire logic        wr_dir;
  wire logic        accept;
  wire logic        is_pwm;
  wire logic [31:0] rdata_next;
  wire logic [1:0]  mode_a;
  wire logic [1:0]  mode_b;
  wire logic [3:0]  wmode_eff;

  assign waveform_mode = {ctrl_b_reg[TWM_B_WHIGH_POS +: 2],
                          ctrl_a_reg[TWM_A_WLOW_POS +: 2]};
  assign mode_dec = decode_mode(waveform_mode);
  assign is_pwm   = mode_dec.kind != TWM_K_NONPWM;
  // Reserved mode runs as normal with both pins released
  assign wmode_eff = mode_dec.reserved ? TWM_WM_NORMAL : waveform_mode;
  assign mode_a = mode_dec.reserved ? 2'b00 : ctrl_a_reg[TWM_A_MODE_A_POS +: 2];
  assign mode_b = mode_dec.reserved ? 2'b00 : ctrl_a_reg[TWM_A_MODE_B_POS +: 2];

  assign top_value = (mode_dec.top_src == TWM_TOP_CMPA) ? chan_a_compare_value_in :
                     (mode_dec.top_src == TWM_TOP_CAP)  ? capture_value_in :
                     mode_dec.top_fixed;
  assign at_top    = count_tick_in && (counter_value_in == top_value);
  assign at_bottom = count_tick_in && (counter_value_in == TWM_BOTTOM);
  assign at_max    = count_tick_in && (counter_value_in == TWM_MAX);

  always_comb begin
    unique case (mode_dec.ovf_at)
      TWM_AT_TOP:    ovf_next = at_top;
      TWM_AT_BOTTOM: ovf_next = at_bottom;
      default:       ovf_next = at_max;
    endcase
    unique case (mode_dec.update_at)
      TWM_AT_TOP:    load_next = at_top;
      TWM_AT_BOTTOM: load_next = at_bottom;
      default:       load_next = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave: waitrequest drops one cycle after the request
  // ----------------------------------------------------------------
  assign accept    = (avs_read_in || avs_write_in) && wait_reg;
  assign wr_ctrl_a = accept && avs_write_in && avs_byteenable_in[0] &&
                     (avs_address_in == TWM_OFS_CTRL_A);
  assign wr_ctrl_b = accept && avs_write_in && avs_byteenable_in[0] &&
                     (avs_address_in == TWM_OFS_CTRL_B);
  assign wr_dir    = accept && avs_write_in && avs_byteenable_in[0] &&
                     (avs_address_in == TWM_OFS_PIN_DIR);
  // Strobe bits are never stored as ones, so they read zero
  assign rdata_next =
    (avs_address_in == TWM_OFS_CTRL_A)  ? {24'h000000, ctrl_a_reg} :
    (avs_address_in == TWM_OFS_CTRL_B)  ? {24'h000000, ctrl_b_reg} :
    (avs_address_in == TWM_OFS_PIN_DIR) ? {30'h00000000, pin_dir_reg} :
    (avs_address_in == TWM_OFS_STATUS)  ?
      {24'h000000, chan_b_override_out, chan_a_override_out,
       chan_b_wave_pin_out, chan_a_wave_pin_out, waveform_mode} :
    32'h00000000;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg  <= !accept;
      if (accept && avs_read_in) rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_a_reg  <= TWM_CTRL_A_RST;
      ctrl_b_reg  <= TWM_CTRL_B_RST;
      pin_dir_reg <= 2'h0;
      force_a_reg <= 1'b0;
      force_b_reg <= 1'b0;
    end else begin
      // Strobe bits masked out of storage
      if (wr_ctrl_a) ctrl_a_reg <= avs_writedata_in[7:0] & 8'hf3;
      if (wr_ctrl_b) ctrl_b_reg <= avs_writedata_in[7:0] & TWM_CTRL_B_WMASK;
      if (wr_dir) pin_dir_reg <= avs_writedata_in[1:0];
      // Strobes use the mode in force before this write; PWM drops them
      force_a_reg <= wr_ctrl_a && avs_writedata_in[TWM_A_FORCE_A] && !is_pwm;
      force_b_reg <= wr_ctrl_a && avs_writedata_in[TWM_A_FORCE_B] && !is_pwm;
    end
  end

  // ----------------------------------------------------------------
  // Status towards timer core
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      top_reg    <= TWM_MAX;
      upd_reg    <= 2'h0;
      ovf_at_reg <= 2'h3;
      dual_reg   <= 1'b0;
      ovf_reg    <= 1'b0;
      load_reg   <= 1'b0;
      clr_reg    <= 1'b0;
    end else begin
      top_reg    <= top_value;
      upd_reg    <= mode_dec.update_at;
      ovf_at_reg <= mode_dec.ovf_at;
      dual_reg   <= (mode_dec.kind == TWM_K_PHASE) || (mode_dec.kind == TWM_K_PFC);
      ovf_reg    <= ovf_next;
      load_reg   <= load_next;
      // Only a real TOP match clears; a forced compare never does
      clr_reg    <= !is_pwm && (mode_dec.top_src != TWM_TOP_FIXED) && at_top;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  wire twm_evt_t evt_a;
  wire twm_evt_t evt_b;
  assign evt_a = '{match: count_tick_in && (counter_value_in == chan_a_compare_value_in),
                   at_top: at_top, up: count_up_in};
  assign evt_b = '{match: count_tick_in && (counter_value_in == chan_b_compare_value_in),
                   at_top: at_top, up: count_up_in};

  twm_channel #(.IS_CHAN_A(1'b1)) u_chan_a (
    .mclk_in       (mclk_in),
    .rstn_in       (rstn_in),
    .out_mode_in   (mode_a),
    .wmode_in      (wmode_eff),
    .kind_in       (mode_dec.kind),
    .evt_in        (evt_a),
    .cmp_eq_top_in (chan_a_compare_value_in == top_value),
    .force_in      (force_a_reg),
    .dir_out_in    (pin_dir_reg[0]),
    .wave_out      (chan_a_wave_pin_out),
    .connect_out   (chan_a_override_out),
    .drive_en_out  (chan_a_wave_pin_oe_out)
  );

  twm_channel #(.IS_CHAN_A(1'b0)) u_chan_b (
    .mclk_in       (mclk_in),
    .rstn_in       (rstn_in),
    .out_mode_in   (mode_b),
    .wmode_in      (wmode_eff),
    .kind_in       (mode_dec.kind),
    .evt_in        (evt_b),
    .cmp_eq_top_in (chan_b_compare_value_in == top_value),
    .force_in      (force_b_reg),
    .dir_out_in    (pin_dir_reg[1]),
    .wave_out      (chan_b_wave_pin_out),
    .connect_out   (chan_b_override_out),
    .drive_en_out  (chan_b_wave_pin_oe_out)
  );

  assign avs_readdata_out      = rdata_reg;
  assign avs_waitrequest_out   = wait_reg;
  assign top_value_out         = top_reg;
  assign update_at_out         = upd_reg;
  assign ovf_at_out            = ovf_at_reg;
  assign dual_slope_out        = dual_reg;
  assign overflow_flag_set_out = ovf_reg;
  assign compare_load_out      = load_reg;
  assign count_clear_out       = clr_reg;
  assign clock_select_out      = ctrl_b_reg[2:0];

endmodule // twm_top

// file: tb/twm_load.sv
// Purpose: External loads on the two compare pins
// Assumes: Each pin line carries a weak pull-down
// Notes:   Released pin reads low, never its last driven level
module twm_load (
  input  wire logic [1:0] pin_in,
  input  wire logic [1:0] oe_in,
  output logic      [1:0] level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  assign level_out = pin_in & oe_in;
endmodule  // twm_load

// file: tb/twm_sva.sv
// Purpose: Port-level assertions for the waveform mode block
// Assumes: Control writes are taken while waitrequest is high
// Notes:   Mode is shadowed from accepted writes, never read back
module twm_sva
  import twm_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rstn_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic        avs_waitrequest_out,
  input wire logic        count_tick_in,
  input wire logic [15:0] chan_a_compare_value_in,
  input wire logic [15:0] capture_value_in,
  input wire logic [15:0] top_value_out,
  input wire logic [1:0]  update_at_out,
  input wire logic [1:0]  ovf_at_out,
  input wire logic        dual_slope_out,
  input wire logic        overflow_flag_set_out,
  input wire logic        count_clear_out,
  input wire logic        chan_a_wave_pin_out,
  input wire logic        chan_a_wave_pin_oe_out,
  input wire logic        chan_a_override_out,
  input wire logic        chan_b_wave_pin_oe_out,
  input wire logic        chan_b_override_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Shadow of the control fields
  // ----------------------------------------------------------------
  logic [7:0]  ca_reg;
  logic [1:0]  cb_reg;
  logic [1:0]  calm_reg;
  wire  [7:0]  wd  = avs_writedata_in[7:0];
  wire         tk  = avs_write_in && avs_waitrequest_out && avs_byteenable_in[0];
  wire         tka = tk && avs_address_in == TWM_OFS_CTRL_A;
  wire         tkb = tk && avs_address_in == TWM_OFS_CTRL_B;
  // Force bits alone do not count as a setting change
  wire         chg = (tka && {wd[7:4], wd[1:0]} != {ca_reg[7:4], ca_reg[1:0]}) ||
                     (tkb && wd[4:3] != cb_reg);
  wire  [3:0]  md  = {cb_reg, ca_reg[1:0]};
  wire         npw = md inside {4'h0, 4'h4, 4'hc};
  wire  [15:0] exp_top = md inside {4'h4, 4'h9, 4'hb, 4'hf} ? chan_a_compare_value_in :
                         md inside {4'h8, 4'ha, 4'hc, 4'he} ? capture_value_in :
                         md inside {4'h1, 4'h5} ? TWM_TOP_8B :
                         md inside {4'h2, 4'h6} ? TWM_TOP_9B :
                         md inside {4'h3, 4'h7} ? TWM_TOP_10B : TWM_MAX;
  wire  [4:0]  exp_pts = md inside {4'h8, 4'h9} ? 5'b10101 :
                         md inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb} ? 5'b01101 :
                         md inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf} ? 5'b01010 : 5'b00110;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ca_reg   <= 8'h00;
      cb_reg   <= 2'h0;
      calm_reg <= 2'h0;
    end else begin
      if (tka) ca_reg <= wd;
      if (tkb) cb_reg <= wd[4:3];
      if (chg || $changed(chan_a_compare_value_in) || $changed(capture_value_in)) calm_reg <= 2'h0;
      else if (calm_reg != 2'h3) calm_reg <= calm_reg + 2'h1;
    end
  end

  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_oe_a_owned: assert property (chan_a_wave_pin_oe_out |-> chan_a_override_out)
    else $error("pin A driven while not owned");
  a_oe_b_owned: assert property (chan_b_wave_pin_oe_out |-> chan_b_override_out)
    else $error("pin B driven while not owned");
  a_one_wait: assert property (tk |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("access did not take exactly one wait");
  a_clear_after_tick: assert property (count_clear_out |-> $past(count_tick_in))
    else $error("counter clear without a tick");
  a_flag_after_tick: assert property (overflow_flag_set_out |-> $past(count_tick_in))
    else $error("overflow flag without a tick");
  a_top_by_mode: assert property (calm_reg == 2'h3 |-> top_value_out == exp_top)
    else $error("top value wrong for mode");
  a_points_mode: assert property (calm_reg == 2'h3 |->
    {update_at_out, ovf_at_out, dual_slope_out} == exp_pts) else $error("event points wrong");
  a_own_nonpwm: assert property (calm_reg == 2'h3 && npw |->
    chan_a_override_out == (ca_reg[7:6] != 2'h0)) else $error("pin A ownership wrong");
  a_pwm_pin_hold: assert property (calm_reg == 2'h3 && !npw && !$past(count_tick_in)
    && !$past(count_tick_in, 2) |-> $stable(chan_a_wave_pin_out)) else $error("pin A moved");

  c_flag: cover property (overflow_flag_set_out);
  c_clear: cover property (count_clear_out);
  c_pwm_calm: cover property (calm_reg == 2'h3 && !npw);
endmodule  // twm_sva

bind twm_top twm_sva u_twm_sva (.*);

// file: tb/twm_top_bench.sv
// Purpose: Self-checking bench for the waveform mode block
// Assumes: Avalon-MM answer comes with one wait state
// Notes:   Pins are watched through the pulled-down load model
module twm_top_bench
  import twm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        tick = 1'b0;
  logic        up = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] cpa = 16'h0010;
  logic [15:0] cpb = 16'h0008;
  logic [15:0] cap = 16'h0040;
  wire  [31:0] rdat;
  wire         wt, pa, pa_oe, pa_ov, pb, pb_oe, pb_ov, flag, clr, ld;
  wire  [1:0]  lvl;
  wire  [2:0]  cs;
  // Outputs caught in the cycle after each tick, load held high in immediate modes: {clear, flag, load}
  logic [2:0]  ev = 3'h0;
  int          failures = 0;
  int          checks_done = 0;

  twm_top u_twm_top (.mclk_in(clk), .rstn_in(rstn), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'h1),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .counter_value_in(cnt),
    .count_up_in(up), .count_tick_in(tick), .chan_a_compare_value_in(cpa),
    .chan_b_compare_value_in(cpb), .capture_value_in(cap), .top_value_out(),
    .update_at_out(), .ovf_at_out(), .dual_slope_out(), .overflow_flag_set_out(flag),
    .compare_load_out(ld), .count_clear_out(clr), .clock_select_out(cs),
    .chan_a_wave_pin_out(pa), .chan_a_wave_pin_oe_out(pa_oe), .chan_a_override_out(pa_ov),
    .chan_b_wave_pin_out(pb), .chan_b_wave_pin_oe_out(pb_oe), .chan_b_override_out(pb_ov));
  twm_load u_twm_load (.pin_in({pb, pa}), .oe_in({pb_oe, pa_oe}), .level_out(lvl));

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fin(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wd  <= {24'h0, d};
    wr  <= w;
    rd  <= !w;
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    fin(q, {24'h0, e});
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic tk(input logic [15:0] c, input logic u);
    @(posedge clk);
    cnt  <= c;
    up   <= u;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    #1;
    ev = {clr, flag, ld};
    settle;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rchk(TWM_OFS_CTRL_A, TWM_CTRL_A_RST);
    w(4'h1, 8'h5a);
    rchk(4'h1, 8'h00);
    w(TWM_OFS_CTRL_A, 8'h0c);
    rchk(TWM_OFS_CTRL_A, 8'h00);
    w(TWM_OFS_CTRL_B, 8'h3a);
    rchk(TWM_OFS_CTRL_B, 8'h1a);
    fin(cs, 3'h2);
    rchk(TWM_OFS_STATUS, 8'h0c);
    w(TWM_OFS_CTRL_B, 8'h00);
    w(TWM_OFS_PIN_DIR, 8'h03);
  endtask
  task automatic t_force;
    logic [1:0] om [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic       ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      w(TWM_OFS_CTRL_A, {om[i], om[i], 4'h0});
      w(TWM_OFS_CTRL_A, {om[i], om[i], 4'hc});
      settle;
      fin({pa, pb, lvl, pa_ov}, {ex[i], ex[i], ex[i], ex[i], 1'b1});
    end
    w(TWM_OFS_CTRL_A, 8'h54);
    settle;
    fin({pa, pb}, 2'b01);
    w(TWM_OFS_PIN_DIR, 8'h01);
    settle;
    fin({pb_oe, lvl[1], pb_ov}, 3'b001);
    w(TWM_OFS_CTRL_A, 8'h00);
    settle;
    fin({pa_ov, pb_ov, pa_oe}, 3'b000);
    w(TWM_OFS_PIN_DIR, 8'h03);
    w(TWM_OFS_CTRL_B, 8'h08);
    tk(16'h0010, 1'b1);
    fin(ev, 3'b101);
    w(TWM_OFS_CTRL_A, 8'hc0);
    w(TWM_OFS_CTRL_A, 8'hc8);
    settle;
    fin(pa, 1'b1);
  endtask
  task automatic t_fast;
    w(TWM_OFS_CTRL_A, 8'hb3);
    w(TWM_OFS_CTRL_B, 8'h18);
    tk(16'h0010, 1'b1);
    fin({pa, pb, ev}, 5'b10011);
    tk(16'h0008, 1'b1);
    fin({pa, pb}, 2'b11);
    w(TWM_OFS_CTRL_A, 8'hbf);
    settle;
    fin({pa, pb}, 2'b11);
    tk(16'h0010, 1'b1);
    fin({pa, pb}, 2'b10);
    w(TWM_OFS_CTRL_A, 8'h53);
    tk(16'h0010, 1'b1);
    fin({pa_ov, pb_ov, pa}, 3'b100);
    w(TWM_OFS_CTRL_A, 8'h52);
    settle;
    fin({pa_ov, pb_ov}, 2'b00);
  endtask
  task automatic t_dual;
    w(TWM_OFS_CTRL_A, 8'hb0);
    w(TWM_OFS_CTRL_B, 8'h10);
    tk(16'h0008, 1'b1);
    fin(pb, 1'b1);
    tk(16'h0010, 1'b0);
    fin(pa, 1'b1);
    tk(16'h0008, 1'b0);
    tk(16'h0010, 1'b1);
    fin({pa, pb}, 2'b00);
    tk(16'h0000, 1'b0);
    fin(ev, 3'b011);
    tk(16'h0040, 1'b1);
    fin(ev, 3'b000);
    w(TWM_OFS_CTRL_A, 8'h51);
    settle;
    fin({pa_ov, pb_ov}, 2'b10);
    w(TWM_OFS_CTRL_A, 8'h53);
    tk(16'h0000, 1'b0);
    fin({pa_ov, pb_ov, ev}, 5'b00010);
  endtask
  task automatic t_modes;
    logic [31:0] q;
    for (int m = 0; m < 16; m++) begin
      if (m == 13) continue;
      w(TWM_OFS_CTRL_A, {6'h00, m[1:0]});
      w(TWM_OFS_CTRL_B, {3'h0, m[3:2], 3'h1});
      bus(1'b0, TWM_OFS_STATUS, 8'h00, q);
      fin(q[3:0], m[3:0]);
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_force;
    t_fast;
    t_dual;
    t_modes;
    close_out;
  end
  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule  // twm_top_bench
